// ### verilog/imb_mode_bank.sv
// register bank, boot sequencer and mode decode of the motion sensor core
// assumes both host ports are parallel strobes from serial logic on mclk
`timescale 1ns/100ps
module imb_mode_bank #(
  parameter int unsigned BOOT_CYCLES = imb_pkg::BOOT_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire imb_pkg::imb_req_t      priReq,
  output imb_pkg::imb_rsp_t           priRsp,
  input  wire imb_pkg::imb_req_t      auxReq,
  output imb_pkg::imb_rsp_t           auxRsp,
  output logic                        bootDone,
  output logic                        stabPinMode,
  output logic                        analogHubOn,
  output logic                        chargeChanOn,
  output imb_pkg::imb_xl_mode_t       accelMode,
  output imb_pkg::imb_g_mode_t        gyroMode,
  output imb_pkg::imb_cfg_t           opConfig,
  output logic                        accelSample,
  output logic                        gyroSample
);
  typedef enum logic [1:0] {ST_BOOT = 2'b01, ST_RUN = 2'b10} imb_state_t;

  imb_state_t  state;
  logic [18:0] bootCnt;
  logic        bootEnd;
  logic [7:0]  bankAccess;
  logic [7:0]  pageSel;
  logic [7:0]  accelCtrl;
  logic [7:0]  gyroCtrl;
  logic [7:0]  analog_frontend_control;
  logic [7:0]  primary_stabilization_control_1;
  logic [7:0]  aux_port_stabilization_control_1;
  logic [7:0]  page0Mem [4];
  logic [7:0]  page2Mem [4];
  logic        embOpen;
  logic        priWr;
  logic        auxWr;
  logic        inWindow;
  logic [1:0]  winIdx;
  logic [7:0]  next_priData;
  logic [7:0]  next_auxData;
  logic        accelOn;
  logic        gyroOn;
  logic        accelRun;
  logic        gyroRun;
  logic        accelTickInt;
  logic        gyroTickInt;

  function automatic logic rateOn(input logic [7:0] ctrl);
    rateOn = (ctrl[3:0] != imb_pkg::ODR_OFF);
  endfunction : rateOn

  function automatic logic [2:0] modeBits(input logic [7:0] ctrl);
    modeBits = ctrl[6:4];
  endfunction : modeBits

  assign bootEnd  = (state == ST_BOOT) && (bootCnt == 19'(BOOT_CYCLES - 1));
  assign embOpen  = bankAccess[imb_pkg::BIT_EMB_ACCESS];
  // no register answers until trimming has loaded
  assign priWr    = priReq.wr && (state == ST_RUN);
  assign auxWr    = auxReq.wr && (state == ST_RUN);
  assign inWindow = (priReq.addr >= imb_pkg::OFF_PAGE_WIN)
                 && (priReq.addr < (imb_pkg::OFF_PAGE_WIN + 8'(imb_pkg::PAGE_WIN_HI)));
  assign winIdx   = priReq.addr[1:0];
  assign accelOn  = rateOn(accelCtrl);
  assign gyroOn   = rateOn(gyroCtrl);
  assign accelRun = accelOn && (modeBits(accelCtrl) != imb_pkg::XL_DOWN);
  assign gyroRun  = gyroOn && (modeBits(gyroCtrl) inside {imb_pkg::G_HP, imb_pkg::G_HIGH_ACCURACY_RATE_MODE,
                                                        imb_pkg::G_TRIG, imb_pkg::G_LP});

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_BOOT;
      bootCnt <= 19'h00000;
    end else begin
      case (state)
        ST_BOOT: begin
          bootCnt <= bootCnt + 19'h00001; // RULE7
          if (bootEnd) begin
            state <= ST_RUN;
          end
        end
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootDone <= 1'b0;
    end else begin
      bootDone <= (state == ST_RUN) || bootEnd;
    end
  end

  // bank access register is reachable in both maps so the host can always leave the bank
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bankAccess <= imb_pkg::RESET_VAL;
      pageSel    <= imb_pkg::RESET_VAL;
    end else if (priWr) begin
      if (priReq.addr == imb_pkg::OFF_BANK_ACCESS) begin
        bankAccess <= priReq.wdata; // RULE5 RULE14
      end
      if (embOpen && priReq.addr == imb_pkg::OFF_PAGE_SEL) begin
        pageSel <= priReq.wdata; // RULE5
      end
    end
  end

  // normal map registers: only the primary port and only with the bank closed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accelCtrl                       <= imb_pkg::RESET_VAL;
      gyroCtrl                        <= imb_pkg::RESET_VAL;
      analog_frontend_control         <= imb_pkg::RESET_VAL;
      primary_stabilization_control_1 <= imb_pkg::RESET_VAL;
    end else if (bootEnd) begin
      accelCtrl[3:0] <= imb_pkg::ODR_OFF; // RULE8
      gyroCtrl[3:0]  <= imb_pkg::ODR_OFF; // RULE8
    end else if (priWr && !embOpen) begin // RULE3 RULE14
      case (priReq.addr)
        imb_pkg::OFF_ACCEL_CTRL: accelCtrl <= priReq.wdata;
        imb_pkg::OFF_GYRO_CTRL:  gyroCtrl <= priReq.wdata;
        imb_pkg::OFF_AFE_CTRL:   analog_frontend_control <= priReq.wdata;
        imb_pkg::OFF_STAB_CTRL1: primary_stabilization_control_1 <= priReq.wdata;
        default: ;
      endcase
    end
  end

  // advanced page storage behind the window; other page codes hit nothing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        page0Mem[i] <= imb_pkg::RESET_VAL;
        page2Mem[i] <= imb_pkg::RESET_VAL;
      end
    end else if (priWr && embOpen && inWindow) begin
      if (pageSel[3:0] == imb_pkg::PAGE_0) begin
        page0Mem[winIdx] <= priReq.wdata; // RULE6
      end else if (pageSel[3:0] == imb_pkg::PAGE_2) begin
        page2Mem[winIdx] <= priReq.wdata; // RULE6
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_port_stabilization_control_1 <= imb_pkg::RESET_VAL;
    end else if (auxWr && auxReq.addr == imb_pkg::OFF_STAB_CTRL1) begin
      aux_port_stabilization_control_1 <= auxReq.wdata; // RULE4
    end
  end

  always_comb begin
    next_priData = imb_pkg::RESET_VAL;
    if (priReq.addr == imb_pkg::OFF_BANK_ACCESS) begin
      next_priData = bankAccess;
    end else if (embOpen) begin // RULE5
      if (priReq.addr == imb_pkg::OFF_PAGE_SEL) begin
        next_priData = pageSel;
      end else if (inWindow && pageSel[3:0] == imb_pkg::PAGE_0) begin
        next_priData = page0Mem[winIdx]; // RULE6
      end else if (inWindow && pageSel[3:0] == imb_pkg::PAGE_2) begin
        next_priData = page2Mem[winIdx]; // RULE6
      end
    end else begin
      case (priReq.addr) // RULE3 RULE14
        imb_pkg::OFF_ACCEL_CTRL: next_priData = accelCtrl;
        imb_pkg::OFF_GYRO_CTRL:  next_priData = gyroCtrl;
        imb_pkg::OFF_AFE_CTRL:   next_priData = analog_frontend_control;
        imb_pkg::OFF_STAB_CTRL1: next_priData = primary_stabilization_control_1;
        imb_pkg::OFF_STATUS:     next_priData = {3'h0, stabPinMode, analogHubOn,
                                                 gyroOn, accelOn, bootDone};
        default:                 next_priData = imb_pkg::RESET_VAL;
      endcase
    end
  end

  always_comb begin
    next_auxData = imb_pkg::RESET_VAL;
    if (auxReq.addr == imb_pkg::OFF_STAB_CTRL1) begin
      next_auxData = aux_port_stabilization_control_1; // RULE4
    end
  end

  // read data lands one cycle after the strobe; reads during boot return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      priRsp <= '0;
      auxRsp <= '0;
    end else begin
      priRsp.rvalid <= priReq.rd;
      priRsp.rdata  <= (priReq.rd && state == ST_RUN) ? next_priData : imb_pkg::RESET_VAL;
      auxRsp.rvalid <= auxReq.rd;
      auxRsp.rdata  <= (auxReq.rd && state == ST_RUN) ? next_auxData : imb_pkg::RESET_VAL;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stabPinMode  <= 1'b0;
      analogHubOn  <= 1'b0;
      chargeChanOn <= 1'b0;
    end else begin
      stabPinMode  <= primary_stabilization_control_1[imb_pkg::BIT_STAB_XL]
                   || primary_stabilization_control_1[imb_pkg::BIT_STAB_G]
                   || aux_port_stabilization_control_1[imb_pkg::BIT_STAB_XL]
                   || aux_port_stabilization_control_1[imb_pkg::BIT_STAB_G]; // RULE1
      analogHubOn  <= analog_frontend_control[imb_pkg::BIT_AFE_EN]; // RULE2
      chargeChanOn <= analog_frontend_control[imb_pkg::BIT_AFE_EN]; // RULE2
    end
  end

  // unknown mode codes fall back to power-down rather than guessing a mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accelMode <= imb_pkg::XL_DOWN;
      gyroMode  <= imb_pkg::G_DOWN;
      opConfig  <= imb_pkg::CFG_IDLE;
    end else begin
      if (!accelOn || modeBits(accelCtrl) == imb_pkg::XL_DOWN) begin
        accelMode <= imb_pkg::XL_DOWN; // RULE13
      end else begin
        accelMode <= imb_pkg::imb_xl_mode_t'(modeBits(accelCtrl)); // RULE11
      end
      case (modeBits(gyroCtrl))
        imb_pkg::G_HP, imb_pkg::G_HIGH_ACCURACY_RATE_MODE, imb_pkg::G_TRIG, imb_pkg::G_SLEEP, imb_pkg::G_LP:
          gyroMode <= gyroOn ? imb_pkg::imb_g_mode_t'(modeBits(gyroCtrl)) // RULE12
                             : imb_pkg::G_DOWN; // RULE13
        default: gyroMode <= imb_pkg::G_DOWN;
      endcase
      case ({accelRun, gyroRun}) // RULE10
        2'b10:   opConfig <= imb_pkg::CFG_XL_ONLY;
        2'b01:   opConfig <= imb_pkg::CFG_G_ONLY;
        2'b11:   opConfig <= imb_pkg::CFG_BOTH;
        default: opConfig <= imb_pkg::CFG_IDLE;
      endcase
    end
  end

  imb_rate_gen u_rate (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (state == ST_RUN),
    .accelOdr  (accelCtrl[3:0]),
    .gyroOdr   (gyroCtrl[3:0]),
    .accelTick (accelTickInt),
    .gyroTick  (gyroTickInt)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accelSample <= 1'b0;
      gyroSample  <= 1'b0;
    end else begin
      accelSample <= accelTickInt && accelMode != imb_pkg::XL_DOWN;
      gyroSample  <= gyroTickInt && gyroMode != imb_pkg::G_DOWN && gyroMode != imb_pkg::G_SLEEP;
    end
  end

  property p_stab_mode;
    @(posedge mclk) disable iff (!rst_n)
      (primary_stabilization_control_1[imb_pkg::BIT_STAB_XL]
       || aux_port_stabilization_control_1[imb_pkg::BIT_STAB_G]) |=> stabPinMode;
  endproperty
  a_stab_mode: assert property (p_stab_mode) else $error("stabilization pin mode not entered"); // RULE1

  property p_afe;
    @(posedge mclk) disable iff (!rst_n)
      ##1 (analogHubOn == $past(analog_frontend_control[imb_pkg::BIT_AFE_EN]))
          && (chargeChanOn == analogHubOn);
  endproperty
  a_afe: assert property (p_afe) else $error("front end enable mismatch"); // RULE2

  property p_aux_no_main;
    @(posedge mclk) disable iff (!rst_n)
      (auxReq.wr && !priReq.wr) |=> $stable(primary_stabilization_control_1) && $stable(accelCtrl);
  endproperty
  a_aux_no_main: assert property (p_aux_no_main) else $error("aux port reached main map"); // RULE3

  property p_pri_no_aux;
    @(posedge mclk) disable iff (!rst_n)
      !auxReq.wr |=> $stable(aux_port_stabilization_control_1);
  endproperty
  a_pri_no_aux: assert property (p_pri_no_aux) else $error("aux register changed by primary"); // RULE4

  property p_bank_closed;
    @(posedge mclk) disable iff (!rst_n)
      (priWr && !embOpen && priReq.addr == imb_pkg::OFF_PAGE_SEL) |=> $stable(pageSel);
  endproperty
  a_bank_closed: assert property (p_bank_closed) else $error("page select written closed"); // RULE5

  property p_page2;
    @(posedge mclk) disable iff (!rst_n)
      (priWr && embOpen && inWindow && pageSel[3:0] == imb_pkg::PAGE_2)
        |=> page2Mem[$past(winIdx)] == $past(priReq.wdata);
  endproperty
  a_page2: assert property (p_page2) else $error("page 2 window write lost"); // RULE6

  property p_boot_len;
    @(posedge mclk) disable iff (!rst_n)
      $rose(bootDone) |-> $past(bootCnt) == 19'(BOOT_CYCLES - 1);
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot length wrong"); // RULE7

  property p_boot_down;
    @(posedge mclk) disable iff (!rst_n)
      bootEnd |=> !accelOn && !gyroOn ##2 accelMode == imb_pkg::XL_DOWN;
  endproperty
  a_boot_down: assert property (p_boot_down) else $error("sensors not down after boot"); // RULE8

  property p_odr_off;
    @(posedge mclk) disable iff (!rst_n)
      (gyroCtrl[3:0] == imb_pkg::ODR_OFF) |=> gyroMode == imb_pkg::G_DOWN;
  endproperty
  a_odr_off: assert property (p_odr_off) else $error("zero rate gyro not down"); // RULE13

  property p_both;
    @(posedge mclk) disable iff (!rst_n)
      (accelRun && gyroRun) |=> opConfig == imb_pkg::CFG_BOTH;
  endproperty
  a_both: assert property (p_both) else $error("both-on configuration missed"); // RULE10

  property p_sync;
    @(posedge mclk) disable iff (!rst_n)
      (accelTickInt && $past(gyroOn) && $past(accelCtrl[3:0]) <= $past(gyroCtrl[3:0])) |-> gyroTickInt;
  endproperty
  a_sync: assert property (p_sync) else $error("accel strobe off gyro grid"); // RULE9

  c_boot:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(bootDone));
  c_both:  cover property (@(posedge mclk) disable iff (!rst_n) opConfig == imb_pkg::CFG_BOTH);
  c_page0: cover property (@(posedge mclk) disable iff (!rst_n)
                           priRsp.rvalid && embOpen && pageSel[3:0] == imb_pkg::PAGE_0);
  c_stab:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(stabPinMode));
endmodule : imb_mode_bank

// ### verilog/imb_pkg.sv
// package for the motion-sensor mode and bank-access block: offsets, fields, modes, carriers
// assumes one 50 MHz clock and register ports already deserialised by the host-port logic
// What this block does
// [RULE1] either stabilization enable bit at 70h set puts auxiliary pins in stabilization mode
// [RULE2] analog hub input and charge-variation channel run only while 16h front enable is 1
// [RULE3] main register map answers the primary host port only, never the auxiliary port
// [RULE4] auxiliary register set answers the auxiliary SPI port only, never the primary port
// [RULE5] embedded-function bank reachable only while embedded bank access bit is 1
// [RULE6] page select 0000 maps advanced page 0, 0010 maps page 2 into the window
// [RULE7] after supply the boot loading trimming finishes within at most 10 ms
// [RULE8] when boot completes both accelerometer and gyroscope are forced to power-down
// [RULE9] with both sensors on, accelerometer sampling is locked to the gyroscope timebase
// [RULE10] configurations: accelerometer only, gyroscope only, or both independently configured
// [RULE11] accelerometer modes: down, three low-power, normal, high-perf, high-accuracy, triggered
// [RULE12] gyroscope modes: down, sleep, low-power, high-perf, high-accuracy, triggered
// [RULE13] a sensor with rate field 0000 is powered down whatever its mode bits say
// [RULE14] embedded bank access bit 0 restores the normal register map
package imb_pkg;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned BOOT_TIME_US  = 10000;
  // longest time, exact count of mclk cycles
  localparam int unsigned BOOT_CYCLES   = BOOT_TIME_US * CLK_MHZ;
  localparam int unsigned BASE_DIV      = 16;

  localparam logic [7:0] OFF_BANK_ACCESS = 8'h01;
  localparam logic [7:0] OFF_PAGE_SEL    = 8'h02;
  localparam logic [7:0] OFF_ACCEL_CTRL  = 8'h10;
  localparam logic [7:0] OFF_GYRO_CTRL   = 8'h11;
  localparam logic [7:0] OFF_AFE_CTRL    = 8'h16;
  localparam logic [7:0] OFF_STATUS      = 8'h1e;
  localparam logic [7:0] OFF_STAB_CTRL1  = 8'h70;
  localparam logic [7:0] OFF_PAGE_WIN    = 8'h40;
  localparam logic [5:0] PAGE_WIN_HI     = 6'h10;

  localparam int unsigned BIT_EMB_ACCESS = 7;
  localparam int unsigned BIT_AFE_EN     = 7;
  localparam int unsigned BIT_STAB_XL    = 2;
  localparam int unsigned BIT_STAB_G     = 1;
  localparam logic [7:0]  RESET_VAL      = 8'h00;
  localparam logic [3:0]  ODR_OFF        = 4'h0;
  localparam logic [3:0]  PAGE_0         = 4'h0;
  localparam logic [3:0]  PAGE_2         = 4'h2;

  // accel/gyro control: [3:0] rate field, [6:4] operating mode
  typedef enum logic [2:0] {
    XL_HP = 3'h0, XL_HIGH_ACCURACY_RATE_MODE = 3'h1, XL_TRIG = 3'h2, XL_LPM1 = 3'h3,
    XL_LPM2 = 3'h4, XL_LPM3 = 3'h5, XL_NORMAL = 3'h6, XL_DOWN = 3'h7
  } imb_xl_mode_t;

  typedef enum logic [2:0] {
    G_HP = 3'h0, G_HIGH_ACCURACY_RATE_MODE = 3'h1, G_TRIG = 3'h2, G_SLEEP = 3'h4,
    G_LP = 3'h5, G_DOWN = 3'h7
  } imb_g_mode_t;

  typedef enum logic [3:0] {
    CFG_IDLE = 4'b0001, CFG_XL_ONLY = 4'b0010, CFG_G_ONLY = 4'b0100, CFG_BOTH = 4'b1000
  } imb_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } imb_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } imb_rsp_t;
endpackage : imb_pkg

// ### verilog/imb_rate_gen.sv
// sample strobe generator for both sensors from one shared phase counter
// assumes rate codes are stable-ish register values on the same clock
`timescale 1ns/100ps
module imb_rate_gen (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] accelOdr,
  input  wire logic [3:0] gyroOdr,
  output logic            accelTick,
  output logic            gyroTick
);
  logic [4:0]  baseCnt;
  logic        baseTick;
  logic [15:0] phase;

  // each code halves the period, so any two rates divide one another
  function automatic logic strobeAt(input logic [15:0] ph, input logic [3:0] code);
    logic [15:0] mask;
    mask = 16'hffff >> code;
    strobeAt = (code != imb_pkg::ODR_OFF) && ((ph & mask) == 16'h0000);
  endfunction : strobeAt

  assign baseTick = (baseCnt == 5'(imb_pkg::BASE_DIV - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baseCnt <= 5'h00;
    end else if (!run || baseTick) begin
      baseCnt <= 5'h00;
    end else begin
      baseCnt <= baseCnt + 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 16'h0000;
    end else if (!run) begin
      phase <= 16'h0000;
    end else if (baseTick) begin
      phase <= phase + 16'h0001;
    end
  end

  // one phase counter serves both sensors, so accel strobes fall on gyro strobes while the accel rate code is at most the gyro code
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accelTick <= 1'b0;
      gyroTick  <= 1'b0;
    end else begin
      accelTick <= run && baseTick && strobeAt(phase, accelOdr); // RULE9
      gyroTick  <= run && baseTick && strobeAt(phase, gyroOdr); // RULE9
    end
  end
endmodule : imb_rate_gen

// ### bench/imb_host_model.sv
// host-processor model driving one register port of the mode and bank-access block
// assumes the port takes a strobe at a rising edge and answers a read one cycle later
`timescale 1ns/100ps
module imb_host_model (
  input  wire logic              mclk,
  output imb_pkg::imb_req_t      req,
  input  wire imb_pkg::imb_rsp_t rsp
);
  initial req = '0;

  // idle bus shows the inverse of the last value so stale data never looks valid
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    @(posedge mclk);
    #1;
    req.wr    = 1'b0;
    req.addr  = ~a;
    req.wdata = ~d;
  endtask : wr_byte

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    req.addr = a;
    req.rd   = 1'b1;
    @(posedge mclk);
    #1;
    req.rd   = 1'b0;
    req.addr = ~a;
    d = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hxx;
  endtask : rd_byte
endmodule : imb_host_model

// ### bench/imu_mode_and_bank_access_bench.sv
// self-checking bench for the mode and bank-access block
// assumes two host models on the primary and auxiliary ports; boot shortened to BOOT cycles
`timescale 1ns/100ps
module imu_mode_and_bank_access_bench;
  localparam int unsigned BOOT  = 20;
  localparam int          LIMIT = 4000;
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  imb_pkg::imb_req_t     priReq;
  imb_pkg::imb_req_t     auxReq;
  imb_pkg::imb_rsp_t     priRsp;
  imb_pkg::imb_rsp_t     auxRsp;
  logic                  bootDone;
  logic                  stabPinMode;
  logic                  analogHubOn;
  logic                  chargeChanOn;
  logic                  accelSample;
  logic                  gyroSample;
  imb_pkg::imb_xl_mode_t accelMode;
  imb_pkg::imb_g_mode_t  gyroMode;
  imb_pkg::imb_cfg_t     opConfig;
  int                    failCount = 0;
  int                    checkCount = 0;
  int                    cycles = 0;
  logic [7:0]            rd;

  always #10 mclk = ~mclk;

  imb_host_model priHost (.mclk(mclk), .req(priReq), .rsp(priRsp));
  imb_host_model auxHost (.mclk(mclk), .req(auxReq), .rsp(auxRsp));

  imb_mode_bank #(.BOOT_CYCLES(BOOT)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .priReq(priReq), .priRsp(priRsp), .auxReq(auxReq),
    .auxRsp(auxRsp), .bootDone(bootDone), .stabPinMode(stabPinMode),
    .analogHubOn(analogHubOn), .chargeChanOn(chargeChanOn), .accelMode(accelMode),
    .gyroMode(gyroMode), .opConfig(opConfig), .accelSample(accelSample),
    .gyroSample(gyroSample)
  );

  task automatic conclude();
    if (failCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic prd(input logic [7:0] a, input logic [7:0] exp);
    priHost.rd_byte(a, rd);
    check(rd, exp);
  endtask : prd

  task automatic ard(input logic [7:0] a, input logic [7:0] exp);
    auxHost.rd_byte(a, rd);
    check(rd, exp);
  endtask : ard

  // a write inside the boot window must be dropped and the sensors end up powered down
  task automatic boot_check();
    int r;
    repeat (8) @(posedge mclk);
    #1;
    check({bootDone, accelMode, gyroMode, opConfig}, {1'b0, 3'h7, 3'h7, 4'h1});
    rst_n = 1'b1;
    r = cycles;
    priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, 8'h61);
    prd(imb_pkg::OFF_ACCEL_CTRL, 8'h00);
    while (bootDone !== 1'b1 && cycles < r + 100) settle(1);
    check(cycles - r, BOOT);
    check({accelMode, gyroMode, opConfig}, {3'h7, 3'h7, 4'h1});
    prd(imb_pkg::OFF_ACCEL_CTRL, 8'h00);
  endtask : boot_check

  task automatic afe_check();
    priHost.wr_byte(imb_pkg::OFF_AFE_CTRL, 8'h80);
    settle(2);
    check({analogHubOn, chargeChanOn}, 2'b11);
    ard(imb_pkg::OFF_AFE_CTRL, 8'h00);
    auxHost.wr_byte(imb_pkg::OFF_AFE_CTRL, 8'h00);
    settle(2);
    check({analogHubOn, chargeChanOn}, 2'b11);
    prd(imb_pkg::OFF_AFE_CTRL, 8'h80);
    priHost.wr_byte(imb_pkg::OFF_AFE_CTRL, 8'h7f);
    settle(2);
    check({analogHubOn, chargeChanOn}, 2'b00);
    priHost.wr_byte(imb_pkg::OFF_AFE_CTRL, 8'h80);
  endtask : afe_check

  task automatic stab_check();
    for (int i = 0; i < 4; i++) begin
      priHost.wr_byte(imb_pkg::OFF_STAB_CTRL1, {5'h00, i[1:0], 1'b0});
      settle(2);
      check(stabPinMode, i != 0);
    end
    priHost.wr_byte(imb_pkg::OFF_STAB_CTRL1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      auxHost.wr_byte(imb_pkg::OFF_STAB_CTRL1, {5'h00, i[1:0], 1'b0});
      settle(2);
      check(stabPinMode, i != 0);
    end
    ard(imb_pkg::OFF_STAB_CTRL1, 8'h06);
    prd(imb_pkg::OFF_STAB_CTRL1, 8'h00);
    auxHost.wr_byte(imb_pkg::OFF_STAB_CTRL1, 8'h00);
  endtask : stab_check

  // window writes in the normal map must vanish; pages keep separate contents
  task automatic bank_check();
    priHost.wr_byte(imb_pkg::OFF_PAGE_SEL, 8'h02);
    priHost.wr_byte(8'h41, 8'h11);
    priHost.wr_byte(imb_pkg::OFF_BANK_ACCESS, 8'h80);
    prd(imb_pkg::OFF_PAGE_SEL, 8'h00);
    prd(imb_pkg::OFF_AFE_CTRL, 8'h00);
    priHost.wr_byte(8'h41, 8'ha5);
    priHost.wr_byte(imb_pkg::OFF_PAGE_SEL, 8'h02);
    prd(8'h41, 8'h00);
    priHost.wr_byte(8'h41, 8'h3c);
    prd(8'h45, 8'h3c);
    priHost.wr_byte(imb_pkg::OFF_PAGE_SEL, 8'h00);
    prd(8'h41, 8'ha5);
    priHost.wr_byte(imb_pkg::OFF_PAGE_SEL, 8'h01);
    prd(8'h41, 8'h00);
    priHost.wr_byte(imb_pkg::OFF_BANK_ACCESS, 8'h00);
    prd(imb_pkg::OFF_AFE_CTRL, 8'h80);
    prd(8'h41, 8'h00);
  endtask : bank_check

  task automatic mode_check();
    for (int m = 0; m < 8; m++) begin
      priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, {1'b0, m[2:0], 4'h1});
      settle(2);
      check(accelMode, m[2:0]);
      check(opConfig, (m == 7) ? 4'h1 : 4'h2);
    end
    priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, 8'h00);
    for (int g = 0; g < 8; g++) begin
      priHost.wr_byte(imb_pkg::OFF_GYRO_CTRL, {1'b0, g[2:0], 4'h1});
      settle(2);
      check(gyroMode, (g inside {0, 1, 2, 4, 5}) ? g[2:0] : 3'h7);
      check(opConfig, (g inside {0, 1, 2, 5}) ? 4'h4 : 4'h1);
    end
    priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, 8'h61);
    priHost.wr_byte(imb_pkg::OFF_GYRO_CTRL, 8'h41);
    settle(2);
    check(opConfig, 4'h2);
    priHost.wr_byte(imb_pkg::OFF_GYRO_CTRL, 8'h01);
    settle(2);
    check(opConfig, 4'h8);
    priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, 8'h60);
    settle(2);
    check({accelMode, opConfig}, {3'h7, 4'h4});
  endtask : mode_check

  // 640 cycles span whole periods of both strobes, so counts are phase-independent
  task automatic sync_check();
    int na;
    int ng;
    int lone;
    na = 0;
    ng = 0;
    lone = 0;
    priHost.wr_byte(imb_pkg::OFF_ACCEL_CTRL, 8'h0e);
    priHost.wr_byte(imb_pkg::OFF_GYRO_CTRL, 8'h0f);
    settle(100);
    repeat (640) begin
      if (accelSample === 1'b1) na++;
      if (gyroSample === 1'b1) ng++;
      if (accelSample === 1'b1 && gyroSample !== 1'b1) lone++;
      settle(1);
    end
    check(na, 10);
    check(ng, 20);
    check(lone, 0);
    prd(imb_pkg::OFF_STATUS, 8'h0f);
  endtask : sync_check

  initial begin
    boot_check();
    afe_check();
    stab_check();
    bank_check();
    mode_check();
    sync_check();
    conclude();
  end
endmodule : imu_mode_and_bank_access_bench
